// *** src/pmb_pkg.sv ***
package pmb_pkg;
  // processor bus shape
  localparam int PROC_DATA_W = 32;
  localparam int PROC_ADDR_W = 16;
  // appended low address bits per word width
  localparam int LSB_BITS_16 = 1;
  localparam int LSB_BITS_32 = 2;
  localparam int BYTE_W = 8;
  // bridge sequencer states
  typedef enum logic [1:0] {
    PMB_IDLE = 2'b00,
    PMB_BUSY = 2'b01,
    PMB_DONE = 2'b10
  } pmb_state_e;
endpackage : pmb_pkg

// *** src/pmb_lane_map.sv ***
module pmb_lane_map #(
  parameter int DATA_W = 32,
  parameter bit BIG_ENDIAN = 1'b0
) (
  // word in processor lane order
  input wire logic [DATA_W-1:0] IN_DATA,
  input wire logic [DATA_W/8-1:0] IN_BE,
  // word in interconnect lane order
  output logic [DATA_W-1:0] OUT_DATA,
  output logic [DATA_W/8-1:0] OUT_BE
);
  localparam int NB = DATA_W / pmb_pkg::BYTE_W;
  localparam int BW = pmb_pkg::BYTE_W;
  // pure lane permutation; bit order inside a byte is kept
  for (genvar i = 0; i < NB; i++) begin : g_lane
    localparam int SRC = BIG_ENDIAN ? (NB - 1 - i) : i;
    assign OUT_DATA[i*BW +: BW] = IN_DATA[SRC*BW +: BW]; // see RQ12 see RQ14 see RQ15
    assign OUT_BE[i] = IN_BE[SRC]; // see RQ5
  end
endmodule // pmb_lane_map

// *** src/pmb_bridge.sv ***
// Summary of operation
// RQ1 - The master side always issues byte addresses, converting the processor word address first.
// RQ2 - With a 16-bit word bus one low address bit is appended.
// RQ3 - With a 32-bit word bus two low address bits are appended.
// RQ4 - Appended low address bits are always zero so addresses stay word aligned.
// RQ5 - Processor byte enables pick byte lanes and are forwarded unchanged; the big-endian build reverses them with the data lanes.
// RQ6 - The processor inserts wait states and holds its transfer while waitrequest is high.
// RQ7 - All bridge logic runs on the processor bus reference clock.
// RQ8 - There is no timeout; a stalled transfer stays pending while waitrequest is high.
// RQ9 - Separate processor read and write buses map straight to readdata and writedata.
// RQ10 - A shared processor data bus is driven from readdata under the processor output enable.
// RQ11 - Conforming control signals pass through; others are adapted by logic.
// RQ12 - Data reaches the interconnect in little-endian lane order, remapping a big-endian bus.
// RQ13 - The least significant byte of a value sits at the lowest byte address.
// RQ14 - Lane mapping does not depend on either party's arithmetic byte order.
// RQ15 - Interconnect data bits 7 down to 0 carry byte offset zero.
// RQ16 - Read data returns to the processor the cycle after waitrequest drops, ending the cycle.
module pmb_bridge #(
  parameter int DATA_W = pmb_pkg::PROC_DATA_W,
  parameter int ADDR_W = pmb_pkg::PROC_ADDR_W,
  parameter bit BIG_ENDIAN = 1'b0,
  parameter bit SHARED_DATA = 1'b0
) (
  // clock and reset (processor bus reference clock)
  input wire logic CLK,
  input wire logic RESET_N,
  // processor bus
  input wire logic [ADDR_W-1:0] P_ADDR,
  input wire logic [DATA_W/8-1:0] P_BE,
  input wire logic P_RD,
  input wire logic P_WR,
  input wire logic [DATA_W-1:0] P_WDATA,
  input wire logic P_OE,
  output logic [DATA_W-1:0] P_RDATA,
  output logic [DATA_W-1:0] P_DQ_O,
  output logic P_DQ_OE,
  output logic P_WAIT,
  output logic P_ACK,
  // memory-mapped master
  output logic [ADDR_W + ((DATA_W == 16) ? pmb_pkg::LSB_BITS_16 : pmb_pkg::LSB_BITS_32) - 1:0]
    M_ADDRESS,
  output logic [DATA_W/8-1:0] M_BYTEENABLE,
  output logic M_READ,
  output logic M_WRITE,
  output logic [DATA_W-1:0] M_WRITEDATA,
  input wire logic [DATA_W-1:0] M_READDATA,
  input wire logic M_WAITREQUEST
);
  localparam int NB = DATA_W / pmb_pkg::BYTE_W;
  localparam int LSB = (DATA_W == 16) ? pmb_pkg::LSB_BITS_16 : pmb_pkg::LSB_BITS_32;

  // sequencer state
  pmb_pkg::pmb_state_e state_reg, state_next;
  logic wait_reg, wait_next;
  logic ack_reg, ack_next;
  // master request state, held toward the fabric
  logic [ADDR_W+LSB-1:0] addr_reg, addr_next;
  logic [NB-1:0] be_reg, be_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  // return path state, held toward the processor
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic oe_reg, oe_next;
  // both data directions after lane mapping
  logic [DATA_W-1:0] lane_wdata;
  logic [NB-1:0] lane_be;
  logic [DATA_W-1:0] lane_rdata;
  // events used by more than one group
  logic take;
  logic finish;

  // a strobe is taken in idle only, and never in the acknowledge cycle:
  // the processor sees the stall drop one edge late and still holds it there
  function automatic logic req_taken(
    input pmb_pkg::pmb_state_e st,
    input logic ack,
    input logic rd,
    input logic wr
  );
    return (st == pmb_pkg::PMB_IDLE) && !ack && (rd || wr);
  endfunction

  // the fabric accepts a held request on the first edge without a stall
  function automatic logic req_accepted(
    input pmb_pkg::pmb_state_e st,
    input logic stall
  );
    return (st == pmb_pkg::PMB_BUSY) && !stall;
  endfunction

  // processor lanes to interconnect lanes on the way out
  pmb_lane_map #(.DATA_W(DATA_W), .BIG_ENDIAN(BIG_ENDIAN)) u_wmap (
    .IN_DATA(P_WDATA),
    .IN_BE(P_BE),
    .OUT_DATA(lane_wdata),
    .OUT_BE(lane_be)
  );
  // the permutation is its own inverse, so reuse it for reads
  pmb_lane_map #(.DATA_W(DATA_W), .BIG_ENDIAN(BIG_ENDIAN)) u_rmap (
    .IN_DATA(M_READDATA),
    .IN_BE('0),
    .OUT_DATA(lane_rdata),
    // byte enables only travel outward
    .OUT_BE()
  );

  assign take = req_taken(state_reg, ack_reg, P_RD, P_WR); // see RQ6
  // no timeout: a stalled request waits as long as the fabric wants
  assign finish = req_accepted(state_reg, M_WAITREQUEST); // see RQ8

  // sequencer: idle, waiting on the fabric, acknowledge
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    ack_next = 1'b0;
    case (state_reg)
      pmb_pkg::PMB_IDLE: begin
        // stall goes up with the fabric request, so the processor holds its cycle
        if (take) begin
          wait_next = 1'b1; // see RQ6
          state_next = pmb_pkg::PMB_BUSY;
        end
      end
      pmb_pkg::PMB_BUSY: begin
        // stays here for as long as waitrequest is high
        if (finish) begin // see RQ8
          state_next = pmb_pkg::PMB_DONE;
        end
      end
      pmb_pkg::PMB_DONE: begin
        // stall and acknowledge change together, one cycle after the data landed
        wait_next = 1'b0; // see RQ16
        ack_next = 1'b1;
        state_next = pmb_pkg::PMB_IDLE;
      end
      default: begin
        wait_next = 1'b0;
        state_next = pmb_pkg::PMB_IDLE;
      end
    endcase
  end

  // single clock domain: the processor reference clock
  always_ff @(posedge CLK or negedge RESET_N) begin // see RQ7
    if (!RESET_N) begin
      state_reg <= pmb_pkg::PMB_IDLE;
      wait_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      ack_reg <= ack_next;
    end
  end

  // master request: captured once, then held until the fabric drops its stall
  always_comb begin
    addr_next = addr_reg;
    be_next = be_reg;
    wdata_next = wdata_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    if (take) begin
      addr_next = {P_ADDR, {LSB{1'b0}}}; // see RQ1 see RQ2 see RQ3 see RQ4
      be_next = lane_be; // see RQ5 see RQ13
      wdata_next = lane_wdata; // see RQ9 see RQ12
      rd_next = P_RD; // see RQ11
      // read wins when both strobes are up
      wr_next = P_WR & ~P_RD;
    end else if (finish) begin
      rd_next = 1'b0;
      wr_next = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin // see RQ7
    if (!RESET_N) begin
      addr_reg <= '0;
      be_reg <= '0;
      wdata_reg <= '0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      be_reg <= be_next;
      wdata_reg <= wdata_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
    end
  end

  // return path: read data from the accepting edge, and the shared bus drive
  always_comb begin
    rdata_next = rdata_reg;
    // drive on the registered processor enable, one edge late; the separate-bus build never drives
    oe_next = SHARED_DATA & P_OE; // see RQ10
    if (finish && rd_reg) begin
      rdata_next = lane_rdata; // see RQ9 see RQ15
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin // see RQ7
    if (!RESET_N) begin
      rdata_reg <= '0;
      oe_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      oe_reg <= oe_next;
    end
  end

  assign M_ADDRESS = addr_reg;
  assign M_BYTEENABLE = be_reg;
  assign M_READ = rd_reg;
  assign M_WRITE = wr_reg;
  assign M_WRITEDATA = wdata_reg;
  assign P_RDATA = rdata_reg;
  assign P_DQ_O = rdata_reg; // see RQ10
  assign P_DQ_OE = oe_reg;
  assign P_WAIT = wait_reg;
  assign P_ACK = ack_reg;
endmodule // pmb_bridge

// *** bench/pmb_bridge_sva.sv ***
module pmb_bridge_sva #(
  parameter bit BIG_ENDIAN = 1'b0
) (
  // clock and processor side
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [15:0] P_ADDR,
  input wire logic [31:0] P_RDATA,
  input wire logic P_WAIT,
  input wire logic P_ACK,
  // fabric side
  input wire logic [17:0] M_ADDRESS,
  input wire logic M_READ,
  input wire logic M_WRITE,
  input wire logic [31:0] M_READDATA,
  input wire logic M_WAITREQUEST
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // processor lane order of a fabric word
  function automatic logic [31:0] to_proc(input logic [31:0] w);
    return BIG_ENDIAN ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
  property p_lsb; (M_READ | M_WRITE) |-> M_ADDRESS[1:0] == 2'h0; endproperty
  a_lsb: assert property (p_lsb) else $error("low bits set");
  property p_adr; $rose(M_READ | M_WRITE) |-> M_ADDRESS[17:2] == $past(P_ADDR); endproperty
  a_adr: assert property (p_adr) else $error("bad address");
  property p_stl; M_READ && M_WAITREQUEST |=> M_READ && $stable(M_ADDRESS); endproperty
  a_stl: assert property (p_stl) else $error("read dropped");
  property p_wst; M_WRITE && M_WAITREQUEST |=> M_WRITE && $stable(M_ADDRESS); endproperty
  a_wst: assert property (p_wst) else $error("write dropped");
  property p_rdd;
    M_READ && !M_WAITREQUEST |=> P_RDATA == to_proc($past(M_READDATA)) ##1 P_ACK;
  endproperty
  a_rdd: assert property (p_rdd) else $error("read return");
  property p_wt; (M_READ | M_WRITE) |-> P_WAIT && !P_ACK; endproperty
  a_wt: assert property (p_wt) else $error("no stall");
  property p_ack; P_ACK |-> !P_WAIT ##1 !P_ACK; endproperty
  a_ack: assert property (p_ack) else $error("ack shape");
  property p_end; $fell(P_WAIT) |-> P_ACK; endproperty
  a_end: assert property (p_end) else $error("no ack");
  property p_one; P_ACK |=> !(M_READ | M_WRITE); endproperty
  a_one: assert property (p_one) else $error("request taken twice");
endmodule // pmb_bridge_sva
bind pmb_bridge pmb_bridge_sva #(.BIG_ENDIAN(BIG_ENDIAN)) i_pmb_bridge_sva (.CLK, .RESET_N,
  .P_ADDR, .P_RDATA, .P_WAIT, .P_ACK, .M_ADDRESS, .M_READ, .M_WRITE, .M_READDATA,
  .M_WAITREQUEST);

// *** bench/pmb_fabric_model.sv ***
module pmb_fabric_model (
  // fabric slave
  input wire logic CLK,
  input wire logic M_READ,
  input wire logic M_WRITE,
  input wire logic [17:0] M_ADDRESS,
  input wire logic [3:0] M_BYTEENABLE,
  input wire logic [31:0] M_WRITEDATA,
  output logic [31:0] M_READDATA = '0,
  output logic M_WAITREQUEST = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  int lat = 0;
  int cnt = 0;
  logic [31:0] wmem = '0;
  logic [17:0] adr = '0;
  logic [3:0] ben = '0;
  wire go = (M_READ | M_WRITE) && M_WAITREQUEST && cnt >= lat;
  always @(posedge CLK) begin
    M_WAITREQUEST <= !go;
    cnt <= (M_READ | M_WRITE) && M_WAITREQUEST ? cnt + 1 : 0;
    // data only valid in the release cycle, toggles otherwise
    M_READDATA <= go ? 32'h0a0b_0c0d ^ 32'(M_ADDRESS) : ~M_READDATA;
    if (go) begin
      adr <= M_ADDRESS;
      ben <= M_BYTEENABLE;
    end
    if (M_WRITE && !M_WAITREQUEST) wmem <= M_WRITEDATA;
  end
endmodule // pmb_fabric_model

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RESET_N = 0, P_RD = 0, P_WR = 0, P_OE = 0, P_DQ_OE, P_WAIT, P_ACK;
  logic M_READ, M_WRITE, M_WAITREQUEST;
  logic [15:0] P_ADDR = '0;
  logic [3:0] P_BE = '0, M_BYTEENABLE;
  logic [31:0] P_WDATA = '0, P_RDATA, P_DQ_O, M_WRITEDATA, M_READDATA, rdv;
  logic [17:0] M_ADDRESS;
  // second bridge: big-endian lanes on a shared data bus, same processor strobes
  logic be_dq_oe, be_wait, be_ack, be_read, be_write, be_waitreq;
  logic [3:0] be_ben;
  logic [31:0] be_rdata, be_dq_o, be_wdata, be_mrdata, rdv_be;
  logic [17:0] be_maddr;
  int failures = 0, samples_checked = 0;
  pmb_bridge i_pmb_bridge (.CLK, .RESET_N, .P_ADDR, .P_BE, .P_RD, .P_WR, .P_WDATA, .P_OE,
    .P_RDATA, .P_DQ_O, .P_DQ_OE, .P_WAIT, .P_ACK, .M_ADDRESS, .M_BYTEENABLE, .M_READ,
    .M_WRITE, .M_WRITEDATA, .M_READDATA, .M_WAITREQUEST);
  pmb_fabric_model i_pmb_fabric_model (.CLK, .M_READ, .M_WRITE, .M_ADDRESS, .M_BYTEENABLE,
    .M_WRITEDATA, .M_READDATA, .M_WAITREQUEST);
  pmb_bridge #(.BIG_ENDIAN(1'b1), .SHARED_DATA(1'b1)) i_pmb_bridge_be (.CLK, .RESET_N, .P_ADDR,
    .P_BE, .P_RD, .P_WR, .P_WDATA, .P_OE, .P_RDATA(be_rdata), .P_DQ_O(be_dq_o),
    .P_DQ_OE(be_dq_oe), .P_WAIT(be_wait), .P_ACK(be_ack), .M_ADDRESS(be_maddr),
    .M_BYTEENABLE(be_ben), .M_READ(be_read), .M_WRITE(be_write), .M_WRITEDATA(be_wdata),
    .M_READDATA(be_mrdata), .M_WAITREQUEST(be_waitreq));
  pmb_fabric_model i_pmb_fabric_model_be (.CLK, .M_READ(be_read), .M_WRITE(be_write),
    .M_ADDRESS(be_maddr), .M_BYTEENABLE(be_ben), .M_WRITEDATA(be_wdata),
    .M_READDATA(be_mrdata), .M_WAITREQUEST(be_waitreq));
  initial forever #50 CLK = ~CLK;
  task automatic chk(input string n, input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [3:0] be,
      input logic [31:0] wd);
    @(posedge CLK);
    {P_RD, P_WR, P_OE} <= {rd, !rd, rd};
    P_ADDR <= a;
    P_BE <= be;
    P_WDATA <= wd;
    do @(posedge CLK); while (P_ACK !== 1'b1);
    rdv = P_RDATA;
    rdv_be = be_rdata;
    chk("ack_swap", {be_ack, be_wait}, 2'b10);
    {P_RD, P_WR, P_OE} <= 3'h0;
    P_ADDR <= ~a;
    P_WDATA <= ~wd;
  endtask
  task automatic t_write;
    for (int i = 0; i < 4; i++) begin
      i_pmb_fabric_model.lat = i;
      i_pmb_fabric_model_be.lat = i;
      xfer(1'b0, 16'hfffc + 16'(i), 4'h1 << i, 32'h0000_00a5 << 8 * i);
      chk("be_swap", i_pmb_fabric_model_be.ben, 4'h8 >> i);
      chk("wdata_swap", i_pmb_fabric_model_be.wmem, 32'ha500_0000 >> 8 * i);
      chk("oe_write", be_dq_oe, 1'b0);
      chk("addr", i_pmb_fabric_model.adr, {16'hfffc + 16'(i), 2'h0});
      chk("be", i_pmb_fabric_model.ben, 4'h1 << i);
      chk("wdata", i_pmb_fabric_model.wmem, 32'h0000_00a5 << 8 * i);
    end
    $display("t_write done");
  endtask
  task automatic t_read;
    logic [31:0] e;
    logic [31:0] s;
    for (int k = 0; k < 2; k++) begin
      e = 32'h0a0b_0c0d ^ {14'h0, 16'h0001 << 15 * k, 2'h0};
      s = {e[7:0], e[15:8], e[23:16], e[31:24]};
      i_pmb_fabric_model.lat = 40 * k;
      i_pmb_fabric_model_be.lat = 40 * k;
      xfer(1'b1, 16'h0001 << 15 * k, 4'hf, 32'h0);
      chk("rdata", rdv, e);
      chk("dq", {P_DQ_OE, P_DQ_O}, {1'b0, e});
      chk("rdata_swap", rdv_be, s);
      chk("dq_shared", {be_dq_oe, be_dq_o}, {1'b1, s});
    end
    $display("t_read done");
  endtask
  task automatic print_verdict;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // about a hundred cycles expected
  initial begin
    repeat (3000) @(posedge CLK);
    failures++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    t_write;
    t_read;
    print_verdict;
  end
endmodule // tb_top
